// ---- include/lrps_params.svh ----
// constants of the logic, rotate, pack and saturate datapath
// assumes a 32-bit avalon-mm slave with word-aligned byte addresses
`ifndef LRPS_PARAMS_SVH
`define LRPS_PARAMS_SVH
// *****************************************************************
// register byte offsets
// *****************************************************************
`define LRPS_OFS_CTRL     5'h00
`define LRPS_OFS_SRC      5'h04
`define LRPS_OFS_DST      5'h08
`define LRPS_OFS_ACC      5'h0C
`define LRPS_OFS_STATUS   5'h10
// *****************************************************************
// control register fields
// *****************************************************************
`define LRPS_CTRL_OP_LSB  0
`define LRPS_CTRL_OP_MSB  2
`define LRPS_CTRL_IMM_LSB 4
`define LRPS_CTRL_IMM_MSB 9
`define LRPS_CTRL_R1_LSB  12
`define LRPS_CTRL_R1_MSB  16
`define LRPS_CTRL_GO      31
// *****************************************************************
// status register fields
// *****************************************************************
`define LRPS_ST_ZERO      0
`define LRPS_ST_NEG       1
`define LRPS_ST_CARRY     2
`define LRPS_ST_BUSY      8
`define LRPS_ST_ILLEGAL   9
// *****************************************************************
// reset values and fixed figures
// *****************************************************************
`define LRPS_RST_WORD     32'h0000_0000
`define LRPS_ALL_ONES     32'hFFFF_FFFF
`define LRPS_NORM_CARRY   32'h0000_0010
`define LRPS_BYTE_MAX     32'h0000_00FF
`define LRPS_NORM_POS     23
`endif

// ---- include/lrps_pkg.sv ----
// types shared by the datapath core and its register wrapper
// assumes the constants header is included by the user files
package lrps_pkg;
    // *************************************************************
    // operation codes, as written into the control register
    // *************************************************************
    typedef enum logic [2:0] {
        LRPS_NORMALISE_COUNT_OP   = 3'b000,
        LRPS_INVERT_OP            = 3'b001,
        LRPS_OR_OP                = 3'b010,
        LRPS_PACK_PIXEL_OP        = 3'b011,
        LRPS_ACCUM_RESULT_MOVE_OP = 3'b100,
        LRPS_ROTATE_RIGHT_REG_OP  = 3'b101,
        LRPS_ROTATE_RIGHT_IMM_OP  = 3'b110,
        LRPS_CLAMP_UNSIGNED_BYTE_OP = 3'b111
    } lrps_op_type;
endpackage : lrps_pkg

// ---- hdl/lrps_core.sv ----
// combinational result and flag logic for one operation
// assumes operands are stable registers fed by the pipeline wrapper
`timescale 1ns/100ps
`include "lrps_params.svh"
module lrps_core #(
    parameter int NORM_POS = `LRPS_NORM_POS
) (
    input  wire lrps_pkg::lrps_op_type op,
    input  wire logic [31:0]           src_val,
    input  wire logic [31:0]           dst_val,
    input  wire logic [31:0]           acc_val,
    input  wire logic [5:0]            imm_count,
    input  wire logic [4:0]            first_register_field,
    output logic      [31:0]           result,
    output logic                       write_dst,
    output logic                       write_flags,
    output logic                       illegal,
    output logic                       zero_flag,
    output logic                       neg_flag,
    output logic                       carry_flag
);
    // *************************************************************
    // helpers
    // *************************************************************
    // rotate right, shared by both rotate operations
    function automatic logic [31:0] lrps_rotr(input logic [31:0] v,
                                              input logic [4:0]  n);
        lrps_rotr = (v >> n) | (v << (6'd32 - {1'b0, n}));
    endfunction : lrps_rotr
    // index of the highest set bit, zero for a zero value
    function automatic logic [4:0] lrps_msb(input logic [31:0] v);
        lrps_msb = 5'h00;
        for (int i = 0; i < 32; i++)
            if (v[i])
                lrps_msb = 5'(i);
    endfunction : lrps_msb

    // *************************************************************
    // operation mux
    // *************************************************************
    // one case per operation; defaults keep every output assigned
    always_comb
    begin
        result      = dst_val;
        write_dst   = 1'b1;
        write_flags = 1'b1;
        illegal     = 1'b0;
        carry_flag  = 1'b0;
        case (op)
            lrps_pkg::LRPS_NORMALISE_COUNT_OP:
            begin
                // count adds straight onto an exponent
                if (src_val == `LRPS_RST_WORD)
                    result = `LRPS_RST_WORD;
                else
                    result = 32'(int'(lrps_msb(src_val)) - NORM_POS);
                carry_flag = (src_val < `LRPS_NORM_CARRY);
            end
            lrps_pkg::LRPS_INVERT_OP:
            begin
                result = dst_val ^ `LRPS_ALL_ONES;
                carry_flag = (dst_val != `LRPS_RST_WORD);
            end
            lrps_pkg::LRPS_OR_OP:
            begin
                result = src_val | dst_val;
                carry_flag = dst_val[31] & src_val[31];
            end
            lrps_pkg::LRPS_PACK_PIXEL_OP:
            begin
                if (first_register_field != 5'h00)
                begin
                    // expansion is not built here: refuse it
                    illegal   = 1'b1;
                    write_dst = 1'b0;
                end
                result = {16'h0000, dst_val[25:22], dst_val[16:13],
                          dst_val[7:0]};
                write_flags = 1'b0;
            end
            lrps_pkg::LRPS_ACCUM_RESULT_MOVE_OP:
            begin
                result      = acc_val;
                write_flags = 1'b0;
            end
            lrps_pkg::LRPS_ROTATE_RIGHT_REG_OP:
            begin
                result = lrps_rotr(dst_val, src_val[4:0]);
                carry_flag = dst_val[31];
            end
            lrps_pkg::LRPS_ROTATE_RIGHT_IMM_OP:
            begin
                result = lrps_rotr(dst_val, imm_count[4:0]);
                carry_flag = dst_val[31];
            end
            lrps_pkg::LRPS_CLAMP_UNSIGNED_BYTE_OP:
            begin
                if (dst_val[31])
                    result = `LRPS_RST_WORD;
                else if (dst_val > `LRPS_BYTE_MAX)
                    result = `LRPS_BYTE_MAX;
                else
                    result = dst_val;
            end
            default:
            begin
                illegal   = 1'b1;
                write_dst = 1'b0;
            end
        endcase
    end

    assign zero_flag = (result == `LRPS_RST_WORD);
    // clamp never yields a negative value, so n clears there
    assign neg_flag  = result[31];
endmodule : lrps_core

// ---- hdl/lrps_top.sv ----
// avalon-mm wrapped datapath: normalise count, invert, or, pack,
// accumulator move, rotates and unsigned byte clamp
// assumes one 40 mhz clock, bus master keeps requests until answered
//
// How it works
// - normalise count is highest set bit index minus NORM_POS, zero for a zero source
// - count adds directly to exponent
// - normalise carry set when source below 10h
// - invert xors destination with all ones
// - invert carry set unless operand zero
// - or combines source and destination
// - or carry is both bit 31 anded
// - zero and negative follow the result
// - pack moves fields, flags untouched
// - pack only when first field zero
// - pack gives sixteen bit pixel
// - accumulator move copies result, flags untouched
// - register rotate uses low five bits
// - rotate carry is old bit 31
// - immediate rotate count is the low five bits, 0 to 31
// - clamp signed value into 0..255
// - operands read cycle 1, written cycle 3
// - or and register rotate read source too
`timescale 1ns/100ps
`include "lrps_params.svh"
module lrps_top #(
    parameter int NORM_POS = `LRPS_NORM_POS
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    // *************************************************************
    // declarations
    // *************************************************************
    logic [31:0]           src_reg;      // source operand register
    logic [31:0]           dst_reg;      // destination register
    logic [31:0]           acc_reg;      // multiply-accumulate result
    logic [31:0]           ctrl_reg;     // last control word written
    logic                  zero_f;       // condition flags
    logic                  neg_f;
    logic                  carry_f;
    logic                  illegal_f;    // last op was refused
    logic                  st1;          // operation issued
    logic                  st2;          // operands read
    logic                  st3;          // result ready to retire
    lrps_pkg::lrps_op_type op_q;         // operation in flight
    logic [5:0]            imm_q;        // immediate rotate count
    logic [4:0]            r1_q;         // first register field
    logic [31:0]           opa;          // latched source operand
    logic [31:0]           opb;          // latched destination operand
    logic [31:0]           res_q;        // result staged for writeback
    logic                  wr_dst_q;
    logic                  wr_flg_q;
    logic                  ill_q;
    logic                  z_q;
    logic                  n_q;
    logic                  c_q;
    logic [31:0]           core_res;     // core outputs
    logic                  core_wr_dst;
    logic                  core_wr_flg;
    logic                  core_ill;
    logic                  core_z;
    logic                  core_n;
    logic                  core_c;
    logic                  busy;         // pipeline not empty
    logic                  accept_wr;    // bus write takes effect
    logic                  go;           // control write starts op
    logic [31:0]           next_rdata;   // read mux

    // merge byte lanes of a write into an old register value
    function automatic logic [31:0] lrps_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        for (int i = 0; i < 4; i++)
            lrps_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    endfunction : lrps_merge

    assign busy      = st1 | st2 | st3;
    // writes land only at the edge where waitrequest is seen low
    assign accept_wr = avs_write & ~avs_waitrequest & clk_en;
    // operand registers are frozen while an op is in flight
    assign go        = accept_wr & ~busy &
                       (avs_address == `LRPS_OFS_CTRL) &
                       avs_byteenable[3] & avs_writedata[`LRPS_CTRL_GO];

    // *************************************************************
    // bus slave
    // *************************************************************
    // read mux; unmapped addresses read as zero
    always_comb
    begin
        next_rdata = `LRPS_RST_WORD;
        case (avs_address)
            `LRPS_OFS_CTRL:   next_rdata = ctrl_reg;
            `LRPS_OFS_SRC:    next_rdata = src_reg;
            `LRPS_OFS_DST:    next_rdata = dst_reg;
            `LRPS_OFS_ACC:    next_rdata = acc_reg;
            `LRPS_OFS_STATUS:
            begin
                next_rdata[`LRPS_ST_ZERO]    = zero_f;
                next_rdata[`LRPS_ST_NEG]     = neg_f;
                next_rdata[`LRPS_ST_CARRY]   = carry_f;
                next_rdata[`LRPS_ST_BUSY]    = busy;
                next_rdata[`LRPS_ST_ILLEGAL] = illegal_f;
            end
            default:          next_rdata = `LRPS_RST_WORD;
        endcase
    end

    // one wait cycle per access: waitrequest drops for one cycle,
    // read data are loaded at the same edge
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `LRPS_RST_WORD;
        end
        else if (clk_en)
        begin
            if ((avs_read | avs_write) & avs_waitrequest)
            begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= avs_read ? next_rdata : `LRPS_RST_WORD;
            end
            else
                avs_waitrequest <= 1'b1;
        end
    end

    // *************************************************************
    // software registers
    // *************************************************************
    // writes while busy are dropped to avoid racing the writeback
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_reg <= `LRPS_RST_WORD;
            src_reg  <= `LRPS_RST_WORD;
            acc_reg  <= `LRPS_RST_WORD;
        end
        else if (accept_wr & ~busy)
        begin
            case (avs_address)
                `LRPS_OFS_CTRL:
                    ctrl_reg <= lrps_merge(ctrl_reg, avs_writedata,
                                           avs_byteenable);
                `LRPS_OFS_SRC:
                    src_reg <= lrps_merge(src_reg, avs_writedata,
                                          avs_byteenable);
                `LRPS_OFS_ACC:
                    acc_reg <= lrps_merge(acc_reg, avs_writedata,
                                          avs_byteenable);
                default:
                    ctrl_reg <= ctrl_reg;
            endcase
        end
    end

    // destination register: bus writes when idle, datapath in cycle 3
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            dst_reg <= `LRPS_RST_WORD;
        else if (clk_en)
        begin
            if (st3 & wr_dst_q)
                dst_reg <= res_q;
            else if (accept_wr & ~busy & (avs_address == `LRPS_OFS_DST))
                dst_reg <= lrps_merge(dst_reg, avs_writedata,
                                      avs_byteenable);
        end
    end

    // *************************************************************
    // pipeline
    // *************************************************************
    // stage valids: issue, operand read, retire
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st1 <= 1'b0;
            st2 <= 1'b0;
            st3 <= 1'b0;
        end
        else if (clk_en)
        begin
            st1 <= go;
            st2 <= st1;
            st3 <= st2;
        end
    end

    // decoded fields latched at issue
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_q  <= lrps_pkg::LRPS_NORMALISE_COUNT_OP;
            imm_q <= 6'h00;
            r1_q  <= 5'h00;
        end
        else if (go)
        begin
            op_q  <= lrps_pkg::lrps_op_type'(
                avs_writedata[`LRPS_CTRL_OP_MSB:`LRPS_CTRL_OP_LSB]);
            imm_q <= avs_writedata[`LRPS_CTRL_IMM_MSB:`LRPS_CTRL_IMM_LSB];
            r1_q  <= avs_writedata[`LRPS_CTRL_R1_MSB:`LRPS_CTRL_R1_LSB];
        end
    end

    // source latched for normalise count, or and register rotate
    // both are latched every time; ops that read only the destination
    // simply ignore the source copy in the core
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            opa <= `LRPS_RST_WORD;
            opb <= `LRPS_RST_WORD;
        end
        else if (clk_en & st1)
        begin
            opa <= src_reg;
            opb <= dst_reg;
        end
    end

    lrps_core #(
        .NORM_POS             (NORM_POS)
    ) u_core (
        .op                   (op_q),
        .src_val              (opa),
        .dst_val              (opb),
        .acc_val              (acc_reg),
        .imm_count            (imm_q),
        .first_register_field (r1_q),
        .result               (core_res),
        .write_dst            (core_wr_dst),
        .write_flags          (core_wr_flg),
        .illegal              (core_ill),
        .zero_flag            (core_z),
        .neg_flag             (core_n),
        .carry_flag           (core_c)
    );

    // result staging in cycle 2
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            res_q    <= `LRPS_RST_WORD;
            wr_dst_q <= 1'b0;
            wr_flg_q <= 1'b0;
            ill_q    <= 1'b0;
            z_q      <= 1'b0;
            n_q      <= 1'b0;
            c_q      <= 1'b0;
        end
        else if (clk_en & st2)
        begin
            res_q    <= core_res;
            wr_dst_q <= core_wr_dst;
            wr_flg_q <= core_wr_flg & ~core_ill;
            ill_q    <= core_ill;
            z_q      <= core_z;
            n_q      <= core_n;
            c_q      <= core_c;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            zero_f    <= 1'b0;
            neg_f     <= 1'b0;
            carry_f   <= 1'b0;
            illegal_f <= 1'b0;
        end
        else if (clk_en & st3)
        begin
            illegal_f <= ill_q;
            if (wr_flg_q)
            begin
                zero_f  <= z_q;
                neg_f   <= n_q;
                carry_f <= c_q;
            end
        end
    end

    // *************************************************************
    // assertions
    // *************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_issue;
        go && $past(clk_en);
    endsequence
    sequence s_run3;
        clk_en [*3];
    endsequence

    a_wait_one_cycle: assert property (
        (avs_read || avs_write) && avs_waitrequest && clk_en
        |=> !avs_waitrequest)
        else $error("waitrequest did not drop after one cycle");
    a_writeback_time: assert property (
        go ##1 s_run3 |-> st3 && $past(st2) && $past(st1, 2))
        else $error("result did not retire in cycle 3");
    a_or_carry_src: assert property (
        st2 && clk_en && op_q == lrps_pkg::LRPS_OR_OP
        |=> c_q == ($past(opa[31]) && $past(opb[31])))
        else $error("or carry not from both bit 31");
    a_rot_carry_old: assert property (
        st2 && clk_en && (op_q == lrps_pkg::LRPS_ROTATE_RIGHT_REG_OP ||
                          op_q == lrps_pkg::LRPS_ROTATE_RIGHT_IMM_OP)
        |=> c_q == $past(opb[31]))
        else $error("rotate carry not old bit 31");
    a_invert_result: assert property (
        st2 && clk_en && op_q == lrps_pkg::LRPS_INVERT_OP
        |=> res_q == ~$past(opb) && c_q == ($past(opb) != 32'h0))
        else $error("invert result or carry wrong");
    a_pack_flags_kept: assert property (
        st3 && clk_en && op_q == lrps_pkg::LRPS_PACK_PIXEL_OP
        |=> $stable(zero_f) && $stable(neg_f) && $stable(carry_f))
        else $error("pack changed the flags");
    a_clamp_range: assert property (
        st2 && clk_en && op_q == lrps_pkg::LRPS_CLAMP_UNSIGNED_BYTE_OP
        |=> res_q <= 32'h0000_00FF &&
            (!$past(opb[31]) || res_q == 32'h0))
        else $error("clamp out of range");
    a_norm_carry: assert property (
        st2 && clk_en && op_q == lrps_pkg::LRPS_NORMALISE_COUNT_OP
        |=> c_q == ($past(opa) < 32'h0000_0010))
        else $error("normalise carry wrong");
    a_dst_retire: assert property (
        st3 && clk_en && wr_dst_q |=> dst_reg == $past(res_q) &&
            (!$past(wr_flg_q) || zero_f == (dst_reg == 32'h0)))
        else $error("destination or zero flag not retired");
    a_busy_window: assert property (
        s_issue |=> busy [*3])
        else $error("busy not held over the pipeline");
endmodule : lrps_top

// ---- tb/lrps_bus_master.sv ----
// avalon-mm master standing in for the processor pipeline
// assumes the slave answers with one low waitrequest cycle
`timescale 1ns/100ps
module lrps_bus_master (
    input  wire logic        sys_clk,
    input  wire logic        avs_waitrequest,
    input  wire logic [31:0] avs_readdata,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable
);
    // idle bus at time zero, all lanes always enabled
    initial
    begin
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_address    = 5'h1F;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hF;
    end
    // one access, held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        ok = (avs_waitrequest === 1'b0);
        q  = avs_readdata;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // released lines flip so stale values never match by luck
        avs_address   <= ~a;
        avs_writedata <= ~d;
    endtask : xfer
endmodule : lrps_bus_master

// ---- tb/testbench.sv ----
// self-checking bench: operand setup, go, poll, result and flags
// assumes the bus master model and the register map of the header
`timescale 1ns/100ps
`include "lrps_params.svh"
module testbench;
    logic        sys_clk;
    logic        rst_b;
    logic        clk_en;
    logic [4:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        wait_req;
    logic [31:0] q;
    int          n_fail;
    int          cmp_count;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
 $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
    lrps_top lrps_top_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(clk_en), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wait_req));
    lrps_bus_master lrps_bus_master_inst (.sys_clk(sys_clk),
        .avs_waitrequest(wait_req), .avs_readdata(rdata),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be));
    // 40 mhz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic final_report;
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // bus access; a hung slave ends the run
    task automatic acc(input logic w, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] r);
        logic ok;
        lrps_bus_master_inst.xfer(w, a, d, r, ok);
        if (!ok)
        begin
            n_fail++;
            final_report();
        end
    endtask : acc
    // load operands, start, wait for idle, check result and flags
    task automatic run(input logic [2:0] op, input logic [5:0] imm,
        input logic [4:0] r1, input logic [31:0] s, input logic [31:0] d,
        input logic [31:0] e, input logic [9:0] f);
        logic [31:0] r;
        int n;
        acc(1'b1, `LRPS_OFS_SRC, s, r);
        acc(1'b1, `LRPS_OFS_DST, d, r);
        acc(1'b1, `LRPS_OFS_CTRL, {1'b1, 14'h0, r1, 2'h0, imm, 1'b0, op}, r);
        n = 0;
        do
        begin
            acc(1'b0, `LRPS_OFS_STATUS, 32'h0, r);
            n++;
        end
        while (r[8] !== 1'b0 && n < 30);
        if (r[8] !== 1'b0)
        begin
            n_fail++;
            final_report();
        end
        acc(1'b0, `LRPS_OFS_DST, 32'h0, r);
        `CHK(r, e)
        acc(1'b0, `LRPS_OFS_STATUS, 32'h0, r);
        `CHK(r[9:0] & 10'h207, f)
    endtask : run
    initial
    begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        n_fail = 0;
        cmp_count = 0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        acc(1'b0, `LRPS_OFS_STATUS, 32'h0, q);
        `CHK(q, 32'h0)
        acc(1'b1, `LRPS_OFS_SRC, 32'hA5A55A5A, q);
        acc(1'b0, `LRPS_OFS_SRC, 32'h0, q);
        `CHK(q, 32'hA5A55A5A)
        acc(1'b0, 5'h14, 32'h0, q);
        `CHK(q, 32'h0)
        run(3'h0, 6'h0, 5'h0, 32'h5, 32'h0, 32'hFFFFFFEB, 10'h6);
        run(3'h0, 6'h0, 5'h0, 32'h800000, 32'h9, 32'h0, 10'h1);
        run(3'h0, 6'h0, 5'h0, 32'h80000000, 32'h0, 32'h8, 10'h0);
        run(3'h1, 6'h0, 5'h0, 32'h0, 32'hFF, 32'hFFFFFF00, 10'h6);
        run(3'h1, 6'h0, 5'h0, 32'h7, 32'h0, 32'hFFFFFFFF, 10'h2);
        run(3'h2, 6'h0, 5'h0, 32'h80000000, 32'h80000001,
            32'h80000001, 10'h6);
        run(3'h2, 6'h0, 5'h0, 32'h80000000, 32'h1, 32'h80000001,
            10'h2);
        run(3'h2, 6'h0, 5'h0, 32'h0, 32'h0, 32'h0, 10'h1);
        run(3'h3, 6'h0, 5'h0, 32'hFFFFFFFF, 32'h8280A13C, 32'hA53C,
            10'h1);
        run(3'h3, 6'h0, 5'h1, 32'h0, 32'h1234, 32'h1234, 10'h201);
        acc(1'b1, `LRPS_OFS_ACC, 32'h87654321, q);
        run(3'h4, 6'h0, 5'h0, 32'h0, 32'h55, 32'h87654321, 10'h1);
        run(3'h5, 6'h0, 5'h0, 32'hFFFFFFE4, 32'h8000000F, 32'hF8000000,
            10'h6);
        run(3'h6, 6'h20, 5'h0, 32'h4, 32'h70000001, 32'h70000001,
            10'h0);
        run(3'h6, 6'h1, 5'h0, 32'h0, 32'h1, 32'h80000000, 10'h2);
        run(3'h6, 6'h1F, 5'h0, 32'h0, 32'h80000000, 32'h1, 10'h4);
        run(3'h7, 6'h0, 5'h0, 32'h0, 32'hFFFFFFFF, 32'h0, 10'h1);
        run(3'h7, 6'h0, 5'h0, 32'h0, 32'h100, 32'hFF, 10'h0);
        run(3'h7, 6'h0, 5'h0, 32'h0, 32'hFF, 32'hFF, 10'h0);
        // a destination write landing in the retire cycle is dropped
        acc(1'b1, `LRPS_OFS_DST, 32'h0F0F0000, q);
        acc(1'b1, `LRPS_OFS_CTRL, 32'h80000001, q);
        acc(1'b1, `LRPS_OFS_DST, 32'h12345678, q);
        acc(1'b0, `LRPS_OFS_DST, 32'h0, q);
        `CHK(q, 32'hF0F0FFFF)
        // clock enable low right after go: the op must still be busy
        acc(1'b1, `LRPS_OFS_CTRL, 32'h80000001, q);
        clk_en <= 1'b0;
        repeat (5) @(posedge sys_clk);
        clk_en <= 1'b1;
        acc(1'b0, `LRPS_OFS_STATUS, 32'h0, q);
        `CHK(q[8], 1'b1)
        repeat (4) @(posedge sys_clk);
        acc(1'b0, `LRPS_OFS_DST, 32'h0, q);
        `CHK(q, 32'h0F0F0000)
        final_report();
    end
endmodule : testbench
